// [include/str_pkg.sv]
package str_pkg;
   localparam int CMD_W        = 4;
   localparam int DATA_W       = 16;
   localparam int COORD_W      = 13;
   localparam int ADDR_W       = 26;
   localparam int QUEUE_DEPTH  = 16;
   localparam int QUEUE_MARGIN = 2;

   // Command codes on the host address lines
   localparam logic [3:0] CMD_PTRN = 4'h0;
   localparam logic [3:0] CMD_I    = 4'h1;
   localparam logic [3:0] CMD_Z    = 4'h2;
   localparam logic [3:0] CMD_Y    = 4'h3;
   localparam logic [3:0] CMD_X    = 4'h4;
   localparam logic [3:0] CMD_TRI  = 4'h5;
   localparam logic [3:0] CMD_LINE = 4'h8;
   localparam logic [3:0] CMD_PARM = 4'hd;
   localparam logic [3:0] CMD_AUX  = 4'he;
   localparam logic [3:0] CMD_INIT = 4'hf;

   // Parameter slots written by PARM after AUX
   localparam logic [3:0] P_MODE    = 4'h0;
   localparam logic [3:0] P_XMIN    = 4'h1;
   localparam logic [3:0] P_XMAX    = 4'h2;
   localparam logic [3:0] P_YMIN    = 4'h3;
   localparam logic [3:0] P_YMAX    = 4'h4;
   localparam logic [3:0] P_DI_SPAN = 4'h5;
   localparam logic [3:0] P_DZ_SPAN = 4'h6;
   localparam logic [3:0] P_DI_EDGE = 4'h7;
   localparam logic [3:0] P_DZ_EDGE = 4'h8;
   localparam logic [3:0] P_DXL     = 4'h9;
   localparam logic [3:0] P_DXR     = 4'ha;
   localparam logic [3:0] P_LINE_Y  = 4'hb;
   localparam logic [3:0] P_SCALE   = 4'hc;

   // Mode bits
   localparam int M_FAST      = 0;
   localparam int M_HIDDEN    = 1;
   localparam int M_CONST     = 2;
   localparam int M_SHORT_CAS = 3;

   localparam logic [3:0]  MODE_RST    = 4'h0;
   localparam logic [12:0] WIN_MIN_RST = 13'h0000;
   localparam logic [12:0] WIN_MAX_RST = 13'h1fff;
   localparam logic [6:0]  SCALE_RST   = 7'h01;
   localparam logic [15:0] MASK_ALL    = 16'hffff;

   typedef struct packed {
      logic [3:0]  code;
      logic [15:0] data;
   } str_cmd_s;

   typedef struct packed {
      logic [12:0] x;
      logic [12:0] y;
      logic [15:0] i;
      logic [15:0] z;
      logic [15:0] mask;
      logic        img;
   } str_pix_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LINE = 4'b0010,
      ST_SPAN = 4'b0100,
      ST_EDGE = 4'b1000
   } str_state_e;
endpackage

// [logic/str_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module str_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16,
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             clr,
   input  wire logic             wr_valid,
   input  wire logic [WIDTH-1:0] wr_data,
   output var  logic             wr_ready,
   output var  logic             rd_valid,
   output var  logic [WIDTH-1:0] rd_data,
   input  wire logic             rd_ready,
   output var  logic [CNT_W-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wp_q;
   logic [PW-1:0]    rp_q;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("queue depth must be a power of two");
   end

   assign wr_ready = count != CNT_W'(DEPTH);
   assign rd_valid = count != '0;
   assign rd_data  = mem[rp_q];
   assign push     = ce && wr_valid && wr_ready;
   assign pop      = ce && rd_ready && rd_valid;

   always_ff @(posedge clk) begin
      if (push && !clr) begin
         mem[wp_q] <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         count <= '0;
      end else if (ce && clr) begin
         wp_q  <= '0;
         rp_q  <= '0;
         count <= '0;
      end else begin
         wp_q  <= wp_q + PW'(push);
         rp_q  <= rp_q + PW'(pop);
         count <= count + CNT_W'(push) - CNT_W'(pop);
      end
   end

   AST_FIFO_COUNT: assert property (@(posedge clk) disable iff (rst)
      (push && !pop && !clr) |=> count == $past(count) + CNT_W'(1))
      else $error("queue count did not follow a lone push");
endmodule // str_fifo
`default_nettype wire

// [logic/str_renderer.sv]
`timescale 1ns/1ps
`default_nettype none
module str_renderer #(
   parameter int FIFO_DEPTH = str_pkg::QUEUE_DEPTH
) (
   input  wire logic                         CLOCK,
   input  wire logic                         RST,
   input  wire logic                         CE,
   input  wire logic                         SYNC_CLR,
   input  wire logic [str_pkg::CMD_W-1:0]    HOST_CMD,
   input  wire logic [str_pkg::DATA_W-1:0]   HOST_DATA_IN,
   input  wire logic                         HOST_WR_N,
   input  wire logic                         HOST_RD_N,
   output var  logic [str_pkg::DATA_W-1:0]   HOST_DATA_OUT,
   output var  logic                         HOST_DATA_OE,
   output var  logic                         QUEUE_SPACE_FLAG,
   input  wire logic                         HOLD_REQ,
   output var  logic                         BUS_RELEASE_ACK,
   output var  logic                         MEM_OE,
   output var  logic [str_pkg::ADDR_W-1:0]   VRAM_ADDR,
   output var  logic [str_pkg::DATA_W-1:0]   INT_WDATA,
   output var  logic [str_pkg::DATA_W-1:0]   DEPTH_WDATA,
   input  wire logic [str_pkg::DATA_W-1:0]   DEPTH_RDATA,
   output var  logic                         SERIAL_CLK_EN,
   output var  logic                         RAS_N,
   output var  logic                         CAS_N,
   output var  logic                         WE_N,
   output var  logic                         DEPTH_WE_N,
   output var  logic [str_pkg::DATA_W-1:0]   WRITE_MASK,
   output var  logic                         IMAGE_FAST,
   output var  logic                         CAS_DECODE_EN
);
   import str_pkg::*;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

   if (FIFO_DEPTH < 4 || FIFO_DEPTH > 4096) begin : g_chk
      $error("queue depth out of range");
   end

   logic [2:0]       strb_s;
   str_cmd_s         bus_s;
   str_cmd_s         cmd;
   logic             wr_n_q;
   logic             rd_n_q;
   logic             q_valid;
   logic             q_pop;
   logic [CNT_W-1:0] q_count;
   str_state_e       state_q;
   logic             run;
   logic             hold_s;
   logic             pipe_busy;

   // Host pins enter through two flops
   str_sync #(.WIDTH(3), .RST_VAL(3'b011)) u_sync_strb (
      .clk(CLOCK), .rst(RST), .ce(CE),
      .d({HOLD_REQ, HOST_RD_N, HOST_WR_N}), .q(strb_s));
   str_sync #(.WIDTH(CMD_W + DATA_W), .RST_VAL(20'h00000)) u_sync_bus (
      .clk(CLOCK), .rst(RST), .ce(CE),
      .d({HOST_CMD, HOST_DATA_IN}), .q(bus_s));

   assign hold_s = strb_s[2];
   wire wr_fall  = wr_n_q && !strb_s[0];
   wire rd_fall  = rd_n_q && !strb_s[1];
   wire rd_rise  = !rd_n_q && strb_s[1];

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
      end else if (CE) begin
         wr_n_q <= strb_s[0];
         rd_n_q <= strb_s[1];
      end
   end

   // Command queue, one entry per write strobe while it has room
   str_fifo #(.WIDTH(CMD_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_queue (
      .clk(CLOCK), .rst(RST), .ce(CE), .clr(SYNC_CLR),
      .wr_valid(wr_fall), .wr_data(bus_s), .wr_ready(),
      .rd_valid(q_valid), .rd_data(cmd), .rd_ready(q_pop),
      .count(q_count));

   assign run   = !hold_s;
   assign q_pop = q_valid && state_q == ST_IDLE && run && !SYNC_CLR;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         QUEUE_SPACE_FLAG <= 1'b1;
      end else if (CE) begin
         QUEUE_SPACE_FLAG <= q_count < CNT_W'(FIFO_DEPTH - QUEUE_MARGIN);
      end
   end

   // Mode and parameter settings
   logic [3:0]  mode_q;
   logic [3:0]  pidx_q;
   logic [12:0] xmin_q, xmax_q, ymin_q, ymax_q, line_y_q;
   logic [15:0] dis_q, dzs_q, die_q, dze_q, dxl_q, dxr_q;
   logic [6:0]  scale_q;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mode_q   <= MODE_RST;
         pidx_q   <= 4'h0;
         xmin_q   <= WIN_MIN_RST;
         ymin_q   <= WIN_MIN_RST;
         xmax_q   <= WIN_MAX_RST;
         ymax_q   <= WIN_MAX_RST;
         line_y_q <= WIN_MIN_RST;
         scale_q  <= SCALE_RST;
         {dis_q, dzs_q, die_q, dze_q, dxl_q, dxr_q} <= '0;
      end else if (CE && q_pop) begin
         case (cmd.code)
            CMD_INIT: begin
               mode_q  <= MODE_RST;
               xmin_q  <= WIN_MIN_RST;
               ymin_q  <= WIN_MIN_RST;
               xmax_q  <= WIN_MAX_RST;
               ymax_q  <= WIN_MAX_RST;
               scale_q <= SCALE_RST;
            end
            CMD_AUX: pidx_q <= cmd.data[3:0];
            CMD_PARM: begin
               pidx_q <= pidx_q + 4'h1;
               case (pidx_q)
                  P_MODE:    mode_q <= cmd.data[3:0];
                  P_XMIN:    xmin_q <= cmd.data[12:0];
                  P_XMAX:    xmax_q <= cmd.data[12:0];
                  P_YMIN:    ymin_q <= cmd.data[12:0];
                  P_YMAX:    ymax_q <= cmd.data[12:0];
                  P_DI_SPAN: dis_q <= cmd.data;
                  P_DZ_SPAN: dzs_q <= cmd.data;
                  P_DI_EDGE: die_q <= cmd.data;
                  P_DZ_EDGE: dze_q <= cmd.data;
                  P_DXL:     dxl_q <= cmd.data;
                  P_DXR:     dxr_q <= cmd.data;
                  P_LINE_Y:  line_y_q <= cmd.data[12:0];
                  P_SCALE:   scale_q <= cmd.data[6:0];
                  default:   pidx_q <= pidx_q;
               endcase
            end
            default: pidx_q <= pidx_q;
         endcase
      end
   end

   wire fast   = mode_q[M_FAST];
   wire cshade = mode_q[M_CONST];
   wire [15:0] dis_t = cshade ? 16'h0000 : dis_q;
   wire [15:0] dzs_t = cshade ? 16'h0000 : dzs_q;
   wire [15:0] die_t = cshade ? 16'h0000 : die_q;
   wire [15:0] dze_t = cshade ? 16'h0000 : dze_q;

   // Drawing engine
   logic [12:0] vx_q, vy_q, cx_q, cy_q, xl_q, xr_q, yend_q, lx1_q, ly1_q;
   logic [15:0] vi_q, vz_q, si_q, sz_q, ei_q, ez_q;
   logic signed [14:0] err_q, ldx_q, ldy_q;
   logic        lsx_q, lsy_q;
   logic [5:0]  rep_q;
   str_pix_s    s0_q, s1_q, s2_q;
   logic        s0_v_q, s1_v_q, s2_v_q;

   wire signed [14:0] ddx = $signed({2'b00, cmd.data[12:0]}) - $signed({2'b00, vx_q});
   wire signed [14:0] ddy = $signed({2'b00, line_y_q}) - $signed({2'b00, vy_q});
   wire signed [14:0] adx = ddx < 0 ? -ddx : ddx;
   wire signed [14:0] ady = ddy < 0 ? -ddy : ddy;
   wire signed [15:0] e2  = {err_q, 1'b0};
   wire stx = e2 >= 16'(ldy_q);
   wire sty = e2 <= 16'(ldx_q);
   wire [5:0]  fm1  = scale_q[5:0] - 6'h01;
   wire [12:0] nxl  = xl_q + dxl_q[12:0];

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         {vx_q, vy_q, cx_q, cy_q, xl_q, xr_q, yend_q, lx1_q, ly1_q} <= '0;
         {vi_q, vz_q, si_q, sz_q, ei_q, ez_q} <= '0;
         {err_q, ldx_q, ldy_q, lsx_q, lsy_q, rep_q} <= '0;
         s0_q   <= '0;
         s0_v_q <= 1'b0;
      end else if (CE && SYNC_CLR) begin
         state_q <= ST_IDLE;
         s0_v_q  <= 1'b0;
      end else if (CE) begin
         s0_v_q <= 1'b0;
         s0_q   <= '{x: cx_q, y: cy_q, i: si_q, z: sz_q, mask: MASK_ALL, img: 1'b0};
         case (state_q)
            ST_IDLE: if (q_pop) begin
               case (cmd.code)
                  CMD_X: vx_q <= cmd.data[12:0];
                  CMD_Y: vy_q <= cmd.data[12:0];
                  CMD_I: vi_q <= cmd.data;
                  CMD_Z: vz_q <= cmd.data;
                  CMD_PTRN: begin
                     s0_v_q <= 1'b1;
                     s0_q   <= '{x: vx_q, y: vy_q, i: fast ? MASK_ALL : cmd.data, z: vz_q,
                                 mask: fast ? cmd.data : MASK_ALL, img: 1'b1};
                     if (scale_q[6]) begin
                        vx_q <= vx_q + 13'(fm1) + 13'h0001;
                     end else if (rep_q == fm1) begin
                        vx_q  <= vx_q + 13'h0001;
                        rep_q <= 6'h00;
                     end else begin
                        rep_q <= rep_q + 6'h01;
                     end
                  end
                  CMD_LINE: begin
                     {cx_q, cy_q, si_q, sz_q} <= {vx_q, vy_q, vi_q, vz_q};
                     lx1_q   <= cmd.data[12:0];
                     ly1_q   <= line_y_q;
                     ldx_q   <= adx;
                     ldy_q   <= -ady;
                     err_q   <= adx - ady;
                     lsx_q   <= ddx < 0;
                     lsy_q   <= ddy < 0;
                     state_q <= ST_LINE;
                  end
                  CMD_TRI: begin
                     {cx_q, xl_q, xr_q, cy_q} <= {vx_q, vx_q, vx_q, vy_q};
                     {si_q, ei_q, sz_q, ez_q} <= {vi_q, vi_q, vz_q, vz_q};
                     yend_q  <= cmd.data[12:0];
                     state_q <= ST_SPAN;
                  end
                  default: rep_q <= rep_q;
               endcase
            end
            ST_LINE: if (run) begin
               s0_v_q <= 1'b1;
               if (cx_q == lx1_q && cy_q == ly1_q) begin
                  state_q <= ST_IDLE;
               end else begin
                  err_q <= err_q + (stx ? ldy_q : 15'sd0) + (sty ? ldx_q : 15'sd0);
                  if (stx) cx_q <= lsx_q ? cx_q - 13'h0001 : cx_q + 13'h0001;
                  if (sty) cy_q <= lsy_q ? cy_q - 13'h0001 : cy_q + 13'h0001;
                  si_q <= si_q + dis_q;
                  sz_q <= sz_q + dzs_q;
               end
            end
            ST_SPAN: if (run) begin
               s0_v_q <= 1'b1;
               if (cx_q >= xr_q) begin
                  state_q <= ST_EDGE;
               end else begin
                  cx_q <= cx_q + 13'h0001;
                  si_q <= si_q + dis_t;
                  sz_q <= sz_q + dzs_t;
               end
            end
            ST_EDGE: if (run) begin
               if (cy_q == yend_q) begin
                  state_q <= ST_IDLE;
               end else begin
                  cy_q    <= cy_q + 13'h0001;
                  xl_q    <= nxl;
                  xr_q    <= xr_q + dxr_q[12:0];
                  cx_q    <= nxl;
                  ei_q    <= ei_q + die_t;
                  ez_q    <= ez_q + dze_t;
                  si_q    <= ei_q + die_t;
                  sz_q    <= ez_q + dze_t;
                  state_q <= ST_SPAN;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Pixel pipeline; serial depth read leads the write by two cycles
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         {s1_q, s2_q} <= '0;
         {s1_v_q, s2_v_q, SERIAL_CLK_EN} <= '0;
      end else if (CE && SYNC_CLR) begin
         {s1_v_q, s2_v_q, SERIAL_CLK_EN} <= '0;
      end else if (CE) begin
         SERIAL_CLK_EN <= s0_v_q;
         s1_q   <= s0_q;
         s1_v_q <= s0_v_q;
         s2_q   <= s1_q;
         s2_v_q <= s1_v_q;
      end
   end

   wire in_win = s2_q.x >= xmin_q && s2_q.x <= xmax_q
              && s2_q.y >= ymin_q && s2_q.y <= ymax_q;
   wire z_pass = !mode_q[M_HIDDEN] || s2_q.img || s2_q.z < DEPTH_RDATA;
   wire wr_ok  = s2_v_q && in_win && z_pass;
   wire [25:0] pix_addr = fast ? {s2_q.y, 4'h0, s2_q.x[12:4]} : {s2_q.y, s2_q.x};

   // Memory strobes and data
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         {RAS_N, CAS_N, WE_N, DEPTH_WE_N} <= 4'hf;
         {VRAM_ADDR, INT_WDATA, DEPTH_WDATA} <= '0;
         WRITE_MASK <= MASK_ALL;
      end else if (CE && SYNC_CLR) begin
         {RAS_N, CAS_N, WE_N, DEPTH_WE_N} <= 4'hf;
      end else if (CE) begin
         RAS_N      <= !wr_ok;
         CAS_N      <= !wr_ok;
         WE_N       <= !wr_ok;
         DEPTH_WE_N <= !(wr_ok && !s2_q.img);
         if (wr_ok) begin
            VRAM_ADDR   <= pix_addr;
            INT_WDATA   <= s2_q.i;
            DEPTH_WDATA <= s2_q.z;
            WRITE_MASK  <= fast ? s2_q.mask : MASK_ALL;
         end
      end
   end

   // Bus hand-over and mode outputs
   assign pipe_busy = s0_v_q || s1_v_q || s2_v_q || !RAS_N;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         BUS_RELEASE_ACK <= 1'b0;
         MEM_OE          <= 1'b0;
         IMAGE_FAST      <= 1'b0;
         CAS_DECODE_EN   <= 1'b1;
      end else if (CE) begin
         BUS_RELEASE_ACK <= hold_s && !pipe_busy;
         MEM_OE          <= !(hold_s && !pipe_busy) && !SYNC_CLR;
         IMAGE_FAST      <= fast;
         CAS_DECODE_EN   <= !fast || mode_q[M_SHORT_CAS];
      end
   end

   // Host status read
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         HOST_DATA_OUT <= 16'h0000;
         HOST_DATA_OE  <= 1'b0;
      end else if (CE) begin
         if (rd_fall) begin
            HOST_DATA_OUT <= {state_q != ST_IDLE || q_valid, BUS_RELEASE_ACK, 14'(q_count)};
            HOST_DATA_OE  <= 1'b1;
         end else if (rd_rise) begin
            HOST_DATA_OE <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   AST_HIDDEN: assert property (
      (CE && s2_v_q && mode_q[M_HIDDEN] && !s2_q.img && s2_q.z >= DEPTH_RDATA) |=> WE_N && DEPTH_WE_N)
      else $error("write despite failed depth test");
   AST_LAG: assert property ((CE && SERIAL_CLK_EN && !SYNC_CLR) |=> s2_v_q)
      else $error("write not two cycles after serial read");
   AST_CLIP: assert property ((CE && s2_v_q && !in_win) |=> WE_N && RAS_N)
      else $error("pixel written outside clip window");
   AST_ADDR: assert property ((CE && wr_ok && !SYNC_CLR) |=> VRAM_ADDR == $past(pix_addr))
      else $error("shared address not presented");
   AST_WE_SINGLE: assert property ((CE && wr_ok && !fast && !SYNC_CLR)
      |=> !WE_N && WRITE_MASK == MASK_ALL)
      else $error("single-pixel write enable missing");
   AST_MASK_FAST: assert property ((CE && wr_ok && fast && !SYNC_CLR)
      |=> $fell(RAS_N) && WRITE_MASK == $past(s2_q.mask))
      else $error("mask not presented with RAS fall");
   AST_ACK: assert property (BUS_RELEASE_ACK |-> RAS_N && !MEM_OE && !SERIAL_CLK_EN)
      else $error("memory driven while bus released");
   AST_INIT: assert property ((CE && q_pop && cmd.code == CMD_INIT) |=> !mode_q[M_FAST])
      else $error("init left wide-bit mode set");
   AST_CLR: assert property ((CE && SYNC_CLR) |=> q_count == '0 && RAS_N && !MEM_OE)
      else $error("clear did not idle the block");
   AST_CONST: assert property ((CE && run && cshade && state_q == ST_SPAN) |=> $stable(si_q))
      else $error("intensity changed in constant shading");

   COV_LINE: cover property (state_q == ST_LINE ##1 state_q == ST_IDLE);
   COV_FAST: cover property (CE && wr_ok && fast);
   COV_HOLD: cover property ($rose(BUS_RELEASE_ACK));
   COV_HIDE: cover property (CE && s2_v_q && !z_pass);
endmodule // str_renderer
`default_nettype wire

// [logic/str_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module str_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

   AST_SYNC_LAG: assert property (@(posedge clk) disable iff (rst)
      ($past(ce) && $past(ce, 2)) |-> q == $past(d, 2))
      else $error("synchroniser lag is not two flops");
endmodule // str_sync
`default_nettype wire

// [tb/str_vram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module str_vram_model (
   input  wire logic        clk,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        sce,
   input  wire logic [15:0] mask,
   input  wire logic [15:0] stored,
   output var  logic [15:0] rdata,
   output var  logic [15:0] mask_q,
   output var  logic        cas_dly
);
   initial rdata = 16'hffff;
   initial mask_q = 16'h0000;
   // Serial port shifts out the stored depth
   always @(posedge clk) if (sce) rdata <= stored;
   // Mask latched as RAS falls
   always @(negedge ras_n) begin
      #1 mask_q = mask;
   end
   // CAS held back one clock
   always @(posedge clk) cas_dly <= cas_n;
endmodule // str_vram_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import str_pkg::*;
   logic        clock = 0, rst = 1, sync_clr = 0, wr_n = 1, rd_n = 1, hold = 0, ce = 1;
   logic [3:0]  cmd = 4'h0;
   logic [15:0] din = 16'h0000, stored = 16'h0000, dout, wmask, rdata, mask_q, iw, zw, pi, pz, s;
   logic        oe, flag, ack, mem_oe, sce, ras_n, cas_n, we_n, fast, cdec, dwe_n, pdw;
   logic [25:0] addr, pa;
   int          failures = 0, n_checks = 0, npix = 0, n0;
   always #25 clock = ~clock;
   str_renderer u_str_renderer (.CLOCK(clock), .RST(rst), .CE(ce), .SYNC_CLR(sync_clr), .HOST_CMD(cmd),
      .HOST_DATA_IN(din), .HOST_WR_N(wr_n), .HOST_RD_N(rd_n), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
      .QUEUE_SPACE_FLAG(flag), .HOLD_REQ(hold), .BUS_RELEASE_ACK(ack), .MEM_OE(mem_oe), .VRAM_ADDR(addr),
      .INT_WDATA(iw), .DEPTH_WDATA(zw), .DEPTH_RDATA(rdata), .SERIAL_CLK_EN(sce), .RAS_N(ras_n), .CAS_N(cas_n),
      .WE_N(we_n), .DEPTH_WE_N(dwe_n), .WRITE_MASK(wmask), .IMAGE_FAST(fast), .CAS_DECODE_EN(cdec));
   str_vram_model u_str_vram_model (.clk(clock), .ras_n(ras_n), .cas_n(cas_n), .sce(sce), .mask(wmask),
      .stored(stored), .rdata(rdata), .mask_q(mask_q), .cas_dly());
   task automatic conclude;
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [25:0] g, input logic [25:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [3:0] c, input logic [15:0] d);
      cmd <= c; din <= d; cyc(3); wr_n <= 0; cyc(3); wr_n <= 1; cyc(3);
   endtask
   task automatic rd;
      rd_n <= 0;
      for (int i = 0; i < 20 && oe !== 1'b1; i++) begin @(posedge clock); #1; end
      if (oe !== 1'b1) begin failures++; conclude(); end
      s = dout; @(posedge clock); rd_n <= 1; cyc(4);
   endtask
   task automatic pix(input int n);
      for (int i = 0; i < 40 && npix - n0 < n; i++) cyc(1);
      cyc(2);
      chk(26'(npix - n0), 26'(n));
   endtask
   // Capture each pixel write
   always @(negedge clock) if (ras_n === 1'b0) begin
      npix++; pa = addr; pi = iw; pz = zw; pdw = dwe_n;
      if (!fast) chk(we_n, 0);
      chk(cas_n, 0);
   end
   task automatic t_queue;
      hold <= 1; cyc(6); chk({ack, mem_oe}, 2'b10);
      repeat (14) wr(CMD_X, 16'h0005);
      rd; chk(s[13:0], 14);
      ce <= 0; wr(CMD_X, 16'h0005); ce <= 1;
      rd; chk(s[13:0], 14);
      chk(flag, 0);
      repeat (3) wr(CMD_X, 16'h0005);
      rd; chk(s[13:0], 16);
      chk(s[14], 1);
      sync_clr <= 1; cyc(1); sync_clr <= 0; cyc(2);
      rd; chk(s[13:0], 0);
      chk(flag, 1);
      hold <= 0; cyc(6); chk(ack, 0);
   endtask
   task automatic t_depth;
      wr(CMD_INIT, 0); wr(CMD_X, 5); wr(CMD_Y, 3); wr(CMD_I, 16'h1234); wr(CMD_Z, 16'h0010);
      wr(CMD_AUX, P_MODE); wr(CMD_PARM, 16'h0002); wr(CMD_AUX, P_LINE_Y); wr(CMD_PARM, 3);
      stored <= 16'h0010; n0 = npix; wr(CMD_LINE, 5); cyc(20); chk(26'(npix - n0), 0);
      stored <= 16'h0011; n0 = npix; wr(CMD_LINE, 5); pix(1);
      chk(pa, {13'd3, 13'd5});
      chk(pdw, 0);
      chk(pz, 16'h0010);
      chk(pi, 16'h1234);
      wr(CMD_AUX, P_XMIN); wr(CMD_PARM, 6);
      n0 = npix; wr(CMD_LINE, 5); cyc(20); chk(26'(npix - n0), 0);
   endtask
   task automatic t_fast;
      wr(CMD_INIT, 0); wr(CMD_X, 16'h0025); wr(CMD_Y, 3); wr(CMD_AUX, P_MODE); wr(CMD_PARM, 1);
      n0 = npix; wr(CMD_PTRN, 16'ha5a5); pix(1);
      chk(fast, 1);
      chk(pa, {13'd3, 4'h0, 9'd2});
      chk(mask_q, 16'ha5a5);
      chk(cdec, 0);
      wr(CMD_INIT, 0); cyc(3); chk(fast, 0);
      chk(cdec, 1);
   endtask
   task automatic t_tri;
      wr(CMD_INIT, 0); wr(CMD_X, 10); wr(CMD_Y, 4); wr(CMD_I, 16'h0500); wr(CMD_Z, 16'h0020);
      wr(CMD_AUX, P_DI_SPAN); wr(CMD_PARM, 16'h0010);
      repeat (4) wr(CMD_PARM, 0);
      wr(CMD_PARM, 1); wr(CMD_AUX, P_LINE_Y); wr(CMD_PARM, 6);
      n0 = npix; wr(CMD_LINE, 13); pix(4);
      chk(pa, {13'd6, 13'd13});
      chk(pi, 16'h0530);
      n0 = npix; wr(CMD_TRI, 5); pix(3);
      chk(pa, {13'd5, 13'd11});
      chk(pi, 16'h0510);
      wr(CMD_AUX, P_MODE); wr(CMD_PARM, 4);
      n0 = npix; wr(CMD_TRI, 5); pix(3);
      chk(pi, 16'h0500);
      chk(pz, 16'h0020);
      wr(CMD_AUX, P_SCALE); wr(CMD_PARM, 16'h0042);
      n0 = npix; wr(CMD_PTRN, 16'h0077); pix(1);
      n0 = npix; wr(CMD_PTRN, 16'h0077); pix(1);
      chk(pa, {13'd4, 13'd12});
      chk(pi, 16'h0077);
      chk(pdw, 1);
   endtask
   initial begin
      cyc(2); rst <= 0; #1;
      chk({ras_n, cas_n, we_n, mem_oe, flag, cdec}, 6'b111011);
      chk(wmask, 16'hffff);
      @(posedge clock);
      t_queue; t_depth; t_tri; t_fast;
      conclude();
   end
   initial begin #1000000; failures++; conclude(); end
endmodule // tb
`default_nettype wire
